// ===== hw/reload_down_counter_timer.sv
// Contract
// - A 16-bit down counter on the clock divides it by one more than the count register value.
// - After power-up the counter stays disabled until the enable command.
// - A write command with command select 0 captures the data bus into the count register.
// - A read command with command select 0 drives the count register onto the data bus.
// - A write strobe with command select 1 resets and stops the counter and output line.
// - A read strobe with command select 1 enables the counter and drives its live value.
// - With select high all strobes and command select are ignored.
// - Once enabled the counter loads the count register and decrements each clock to zero.
// - At zero it reloads from the count register and keeps running.
// - A new count register value is taken only at the next reload.
// - Writing zero to the count register makes the counter stop at zero after the count.
// - The output line starts low and inverts each time the counter reaches zero.
// - The live count can be read while running and is held stable until the read ends.
module reload_down_counter_timer
  import timer_pkg::*;
(
  input  wire logic                       CLOCK,
  input  wire logic                       SYS_RST,
  input  wire logic                       SELECT_N,
  input  wire logic                       READ_STROBE_N,
  input  wire logic                       WRITE_STROBE_N,
  input  wire logic                       COMMAND_SELECT,
  input  wire logic [timer_pkg::COUNT_W-1:0] DATA_BUS_PINS_IN,
  output logic      [timer_pkg::COUNT_W-1:0] DATA_BUS_PINS_OUT,
  output logic                            DATA_BUS_PINS_OE_N,
  output logic                            TIMER_OUT
);
  import timer_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10,
    ST_PARK = 2'b11
  } run_state_t;

  function automatic logic is_zero(input logic [COUNT_W-1:0] value);
    return (value == COUNT_ZERO);
  endfunction : is_zero

  timer_cmd_if cmd ();

  timer_bus_decode u_dec (
    .clk     (CLOCK),
    .rst     (SYS_RST),
    .sel_n   (SELECT_N),
    .rd_n    (READ_STROBE_N),
    .wr_n    (WRITE_STROBE_N),
    .cmd_sel (COMMAND_SELECT),
    .din     (DATA_BUS_PINS_IN),
    .cmd     (cmd.dec)
  );

  // decoder strobes, one clock each except rd_cmd, which stays high for the whole read
  logic               wr_cmd;
  logic               rd_cmd;
  logic               stop_cmd;
  logic               enable_cmd;
  logic [COUNT_W-1:0] wdata;

  assign wr_cmd     = cmd.wr_reg;
  assign rd_cmd     = cmd.rd_reg;
  assign stop_cmd   = cmd.stop;
  assign enable_cmd = cmd.enable;
  assign wdata      = cmd.wdata;

  // counter and bus state
  run_state_t         state_ff;
  run_state_t         nxt_state;
  logic [COUNT_W-1:0] reload_value_ff;
  logic [COUNT_W-1:0] nxt_reload_value;
  logic [COUNT_W-1:0] count_ff;
  logic [COUNT_W-1:0] nxt_count;
  logic [COUNT_W-1:0] count_dec;
  logic               out_ff;
  logic               nxt_out;
  logic               toggle;
  logic [COUNT_W-1:0] rdata_ff;
  logic [COUNT_W-1:0] nxt_rdata;
  logic [COUNT_W-1:0] rdata_src;
  logic               rd_active_ff;
  logic               nxt_rd_active;

  // decoded run state
  logic               loading;
  logic               running;
  logic               parked;
  logic               count_zero;
  logic               reload_zero;
  logic               expire;
  logic               restart;
  logic               reload_now;
  logic               rd_start;

  assign loading     = (state_ff == ST_LOAD);
  assign running     = (state_ff == ST_RUN);
  assign parked      = (state_ff == ST_PARK);
  assign count_zero  = is_zero(count_ff);
  assign reload_zero = is_zero(reload_value_ff);
  // last one-shot count expires like any other
  assign expire      = running && count_zero;
  // parked counter wakes on a fresh nonzero count
  assign restart     = parked && !reload_zero;
  // count register sampled only here, so a write mid-count waits
  assign reload_now  = loading || expire || restart;
  assign rd_start    = rd_cmd && !rd_active_ff;
  assign count_dec   = count_ff - 16'h0001;

  assign nxt_reload_value = wr_cmd ? wdata : reload_value_ff;

  assign nxt_count = stop_cmd   ? COUNT_ZERO      :
                     reload_now ? reload_value_ff :
                     running    ? count_dec       :
                                  count_ff;

  // parked zeros hold the line, so the one-shot gives a single edge
  assign toggle  = expire;
  assign nxt_out = stop_cmd ? 1'b0    :
                   toggle   ? !out_ff :
                              out_ff;

  // enable reads the live count, a plain read the count register
  assign rdata_src = enable_cmd ? count_ff : reload_value_ff;
  // snapshot once at read start: pins stay still while the count moves
  assign nxt_rdata = rd_start ? rdata_src : rdata_ff;

  assign nxt_rd_active = rd_cmd;

  // run control
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (enable_cmd) begin
          nxt_state = ST_LOAD;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_LOAD: begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        if (expire && reload_zero) begin
          nxt_state = ST_PARK;
        end else begin
          nxt_state = ST_RUN;
        end
      end
      ST_PARK: begin
        if (restart) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_state = ST_PARK;
        end
      end
    endcase
    if (stop_cmd) begin
      nxt_state = ST_IDLE;
    end
  end

  // run state
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // count register
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      reload_value_ff <= RELOAD_RST;
    end else begin
      reload_value_ff <= nxt_reload_value;
    end
  end

  // down counter
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      count_ff <= COUNT_ZERO;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // output line
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  // read snapshot
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_ff <= COUNT_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // bus turn-round
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_active_ff <= 1'b0;
    end else begin
      rd_active_ff <= nxt_rd_active;
    end
  end

  // pins turn round two to three clocks after the strobes move
  assign DATA_BUS_PINS_OE_N = !rd_active_ff;
  assign DATA_BUS_PINS_OUT  = rdata_ff;
  assign TIMER_OUT          = out_ff;
endmodule : reload_down_counter_timer

// ===== pkg/timer_pkg.sv
package timer_pkg;
  localparam int          COUNT_W      = 16;
  localparam logic [15:0] RELOAD_RST   = 16'h0000;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;
  localparam int          SYNC_STAGES  = 2;
  // command_select values
  localparam logic        CMD_REG      = 1'b0;
  localparam logic        CMD_CTRL     = 1'b1;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10
  } bus_op_t;
endpackage : timer_pkg

// ===== pkg/timer_cmd_if.sv
interface timer_cmd_if;
  logic        wr_reg;
  logic        rd_reg;
  logic        stop;
  logic        enable;
  logic [15:0] wdata;
  modport dec (output wr_reg, output rd_reg, output stop, output enable, output wdata);
  modport core (input wr_reg, input rd_reg, input stop, input enable, input wdata);
endinterface : timer_cmd_if

// ===== hw/timer_bus_decode.sv
module timer_bus_decode
  import timer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sel_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        cmd_sel,
  input  wire logic [15:0] din,
  timer_cmd_if.dec         cmd
);
  logic [1:0]  sel_sync_ff, rd_sync_ff, wr_sync_ff, cs_sync_ff;
  logic [15:0] din_a_ff, din_b_ff;
  bus_op_t     op_ff;
  wire         sel_s = sel_sync_ff[1];
  wire         rd_s  = rd_sync_ff[1];
  wire         wr_s  = wr_sync_ff[1];
  wire         cs_s  = cs_sync_ff[1];
  // only selected cycles decode; deselected strobes are ignored
  wire         is_wr = !sel_s && rd_s && !wr_s;
  wire         is_rd = !sel_s && !rd_s && wr_s;
  bus_op_t     nxt_op;
  assign nxt_op = is_wr ? BUS_WRITE : (is_rd ? BUS_READ : BUS_IDLE);
  // write, stop and enable act once, on entry into an operation
  wire         new_op = (nxt_op != op_ff);
  assign cmd.wr_reg = new_op && is_wr && cs_s == CMD_REG;
  assign cmd.stop   = new_op && is_wr && cs_s == CMD_CTRL;
  assign cmd.enable = new_op && is_rd && cs_s == CMD_CTRL;
  assign cmd.rd_reg = is_rd;
  assign cmd.wdata  = din_b_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_sync_ff <= 2'h3;
      rd_sync_ff  <= 2'h3;
      wr_sync_ff  <= 2'h3;
      cs_sync_ff  <= 2'h0;
      din_a_ff    <= 16'h0000;
      din_b_ff    <= 16'h0000;
      op_ff       <= BUS_IDLE;
    end else begin
      sel_sync_ff <= {sel_sync_ff[0], sel_n};
      rd_sync_ff  <= {rd_sync_ff[0], rd_n};
      wr_sync_ff  <= {wr_sync_ff[0], wr_n};
      cs_sync_ff  <= {cs_sync_ff[0], cmd_sel};
      din_a_ff    <= din;
      din_b_ff    <= din_a_ff;
      op_ff       <= nxt_op;
    end
  end
endmodule : timer_bus_decode

// ===== dv/timer_checker.sv
module timer_checker (
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic        SELECT_N,
  input wire logic        READ_STROBE_N,
  input wire logic        WRITE_STROBE_N,
  input wire logic        COMMAND_SELECT,
  input wire logic [15:0] DATA_BUS_PINS_IN,
  input wire logic [15:0] DATA_BUS_PINS_OUT,
  input wire logic        DATA_BUS_PINS_OE_N,
  input wire logic        TIMER_OUT
);
  wire logic rd_pat = !SELECT_N && !READ_STROBE_N && WRITE_STROBE_N;
  wire logic stop_pat = !SELECT_N && READ_STROBE_N && !WRITE_STROBE_N && COMMAND_SELECT;
  logic      en_seen_ff;
  // pin-level flag, ahead of the synchroniser, so it never lags the design
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) en_seen_ff <= 1'b0;
    else if (rd_pat && COMMAND_SELECT) en_seen_ff <= 1'b1;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  AST_OE_SEL: assert property (SELECT_N [*5] |-> DATA_BUS_PINS_OE_N)
    else $error("bus driven while deselected");
  AST_OE_RD: assert property (READ_STROBE_N [*5] |-> DATA_BUS_PINS_OE_N)
    else $error("bus driven without read");
  AST_OE_WR: assert property (!WRITE_STROBE_N [*5] |-> DATA_BUS_PINS_OE_N)
    else $error("bus driven during write");
  AST_RD_ANS: assert property (rd_pat [*6] |-> !DATA_BUS_PINS_OE_N)
    else $error("read not answered");
  AST_RD_HOLD: assert property (!DATA_BUS_PINS_OE_N && $past(!DATA_BUS_PINS_OE_N) |-> $stable(DATA_BUS_PINS_OUT))
    else $error("read data moved");
  AST_STOP: assert property (stop_pat [*5] |-> !TIMER_OUT)
    else $error("output not cleared by stop");
  AST_NO_EN: assert property (!en_seen_ff |-> !TIMER_OUT)
    else $error("output moved before enable");
  AST_RST: assert property ($fell(SYS_RST) |-> DATA_BUS_PINS_OE_N && !TIMER_OUT)
    else $error("bad state after reset");
endmodule : timer_checker
bind reload_down_counter_timer timer_checker chk_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .SELECT_N(SELECT_N),
  .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N), .COMMAND_SELECT(COMMAND_SELECT),
  .DATA_BUS_PINS_IN(DATA_BUS_PINS_IN), .DATA_BUS_PINS_OUT(DATA_BUS_PINS_OUT),
  .DATA_BUS_PINS_OE_N(DATA_BUS_PINS_OE_N), .TIMER_OUT(TIMER_OUT));

// ===== dv/bus_master_model.sv
module bus_master_model (
  input  wire logic        clk,
  input  wire logic        oe_n,
  input  wire logic [15:0] dout,
  output logic             sel_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             cmd_sel,
  output logic [15:0]      bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        drv = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] last_ff = 16'h0000;
  initial {sel_n, rd_n, wr_n, cmd_sel} = 4'hE;
  // floating bus flips every cycle so a stale value cannot pass
  assign bus = !oe_n ? dout : drv ? wd : ~last_ff;
  always @(posedge clk) last_ff <= bus;
  task automatic cmd(input logic s, r, w, c, input logic [15:0] d, output logic [15:0] q);
    int i;
    @(negedge clk);
    {sel_n, rd_n, wr_n, cmd_sel} = {s, r, w, c};
    drv = !w;
    wd = d;
    repeat (6) @(negedge clk);
    for (i = 0; i < 12 && !r && oe_n; i++) @(negedge clk);
    q = bus;
    {sel_n, rd_n, wr_n, cmd_sel} = 4'hE;
    drv = 1'b0;
    repeat (6) @(negedge clk);
  endtask : cmd
endmodule : bus_master_model

// ===== dv/reloadable_down_counter_timer_test.sv
module reloadable_down_counter_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 1'b0, SYS_RST = 1'b1, sel_n, rd_n, wr_n, cmd_sel, oe_n, tout, t;
  logic [15:0] din, dout, q;
  int n_fail = 0, compares = 0, n;
  always #2 CLOCK = ~CLOCK;
  bus_master_model m_u (.clk(CLOCK), .oe_n(oe_n), .dout(dout), .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n),
    .cmd_sel(cmd_sel), .bus(din));
  reload_down_counter_timer dut_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .SELECT_N(sel_n), .READ_STROBE_N(rd_n),
    .WRITE_STROBE_N(wr_n), .COMMAND_SELECT(cmd_sel), .DATA_BUS_PINS_IN(din), .DATA_BUS_PINS_OUT(dout),
    .DATA_BUS_PINS_OE_N(oe_n), .TIMER_OUT(tout));
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // interval between two output edges, bounded so a dead output cannot hang
  task automatic per(output int k);
    t = tout;
    for (k = 0; tout === t && k < 200; k++) @(negedge CLOCK);
    t = tout;
    for (k = 0; tout === t && k < 200; k++) @(negedge CLOCK);
  endtask : per
  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    #20000;
    n_fail++;
    results();
  end
  initial begin
    repeat (8) @(negedge CLOCK);
    SYS_RST = 1'b0;
    chk({14'h0000, oe_n, tout}, 16'h0002);
    m_u.cmd(0, 1, 0, 0, 16'h0005, q);
    m_u.cmd(1, 1, 0, 0, 16'h0009, q);
    m_u.cmd(0, 0, 1, 0, 16'h0000, q);
    chk(q, 16'h0005);
    m_u.cmd(0, 0, 1, 1, 16'h0000, q);
    chk(q, 16'h0000);
    per(n);
    chk(n[15:0], 16'h0006);
    m_u.cmd(0, 1, 0, 0, 16'h0009, q);
    per(n);
    per(n);
    chk(n[15:0], 16'h000A);
    m_u.cmd(0, 0, 1, 1, 16'h0000, q);
    chk({15'h0000, q <= 16'h0009}, 16'h0001);
    m_u.cmd(0, 1, 0, 0, 16'h0000, q);
    repeat (30) @(negedge CLOCK);
    t = tout;
    repeat (40) @(negedge CLOCK);
    chk({15'h0000, tout}, {15'h0000, t});
    m_u.cmd(0, 1, 0, 1, 16'h0000, q);
    m_u.cmd(0, 1, 0, 0, 16'h0007, q);
    m_u.cmd(0, 0, 1, 1, 16'h0000, q);
    per(n);
    chk(n[15:0], 16'h0008);
    m_u.cmd(0, 1, 0, 1, 16'h0000, q);
    repeat (30) @(negedge CLOCK);
    chk({15'h0000, tout}, 16'h0000);
    // long count, so the zero write lands well before expiry
    m_u.cmd(0, 1, 0, 0, 16'h0028, q);
    m_u.cmd(0, 0, 1, 1, 16'h0000, q);
    m_u.cmd(0, 1, 0, 0, 16'h0000, q);
    repeat (60) @(negedge CLOCK);
    chk({15'h0000, tout}, 16'h0001);
    repeat (40) @(negedge CLOCK);
    chk({15'h0000, tout}, 16'h0001);
    results();
  end
endmodule : reloadable_down_counter_timer_test
